/* File: verilog/dtc_pkg.sv */
`default_nettype none

package dtc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int C0_W    = 8;
  localparam int C1_W    = 16;
  localparam int DATA_W  = 8;
  localparam int SEL_W   = 3;
  localparam int PSC_W   = 7;

  // ---------------------------------------------------------------
  // register select codes
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] REG_C0_COUNT = 3'h0;
  localparam logic [SEL_W-1:0] REG_C1_LOW   = 3'h1;
  localparam logic [SEL_W-1:0] REG_C1_HIGH  = 3'h2;
  localparam logic [SEL_W-1:0] REG_C0_CTRL  = 3'h3;
  localparam logic [SEL_W-1:0] REG_C1_CTRL  = 3'h4;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int RUN_BIT  = 4;
  localparam int EDGE_BIT = 3;
  localparam int PSC_HI   = 2;
  localparam int PSC_LO   = 0;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;

  localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] C0_CTRL_MASK = 8'hDF;
  localparam logic [DATA_W-1:0] C1_CTRL_MASK = 8'hD8;
  localparam logic [DATA_W-1:0] RDATA_RESET  = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [1:0] INSN_DIV_LAST = 2'h3;

  typedef enum logic {DTC_PW_WAIT, DTC_PW_MEAS} dtc_pw_e;

endpackage

`default_nettype wire

/* File: verilog/dtc_pin_edge.sv */
`timescale 1ns/1ps
`default_nettype none

module dtc_pin_edge (
  input  wire logic clk,     // system clock
  input  wire logic rst,     // sync reset
  input  wire logic ce,      // clock enable
  input  wire logic pin,     // asynchronous timer pin
  output logic      rise,    // low to high seen
  output logic      fall     // high to low seen
);
  import dtc_pkg::*;

  logic       meta_q;
  logic       sync_q;
  logic       prev_q;
  logic [1:0] prime_q;

  // ---------------------------------------------------------------
  // two-stage synchroniser, then one stage of history
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      prev_q  <= 1'b0;
      prime_q <= 2'h0;
    end else if (ce) begin
      meta_q  <= pin;
      sync_q  <= meta_q;
      prev_q  <= sync_q;
      prime_q <= {prime_q[0], 1'b1};
    end
  end

  // edges are held off for two enabled cycles only, so a pin high at reset
  // release still reaches sync_q before prev_q and shows as a rising transition
  assign rise = prime_q[1] & sync_q & ~prev_q;
  assign fall = prime_q[1] & ~sync_q & prev_q;

endmodule // dtc_pin_edge

`default_nettype wire

/* File: verilog/dtc_count_core.sv */
`timescale 1ns/1ps
`default_nettype none

module dtc_count_core #(
  parameter int W = 8
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst,      // sync reset
  input  wire logic         ce,       // clock enable
  input  wire logic         inc,      // one count step
  input  wire logic         pre_wr,   // preload write strobe
  input  wire logic [W-1:0] pre_val,  // preload write value
  input  wire logic         running,  // run control
  output logic      [W-1:0] count_q,  // live count
  output logic              ovf_q     // overflow pulse
);
  import dtc_pkg::*;

  logic [W-1:0] preload_q;
  wire          at_full = &count_q;
  wire          direct  = pre_wr & ~running;

  // preload has no reset: it is undefined until software writes it
  always_ff @(posedge clk) begin
    if (ce && pre_wr) begin
      preload_q <= pre_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      ovf_q   <= 1'b0;
    end else if (ce) begin
      ovf_q <= 1'b0;
      if (direct) begin
        count_q <= pre_val;
      end else if (inc && at_full) begin
        count_q <= preload_q;
        ovf_q   <= 1'b1;
      end else if (inc) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ovf_reload: assert property (@(posedge clk) disable iff (rst)
    ce && inc && at_full && !direct |=> ovf_q && count_q == $past(preload_q))
    else $error("overflow did not reload preload");

  a_count_step: assert property (@(posedge clk) disable iff (rst)
    ce && inc && !at_full && !direct |=> !ovf_q && count_q == $past(count_q) + 1'b1)
    else $error("count did not step by one");

  a_stop_copy: assert property (@(posedge clk) disable iff (rst)
    ce && direct |=> count_q == $past(pre_val))
    else $error("stopped preload write not copied");

endmodule // dtc_count_core

`default_nettype wire

/* File: verilog/dtc_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - 8-bit and 16-bit up counters
// - mode field in control bits 7:6
// - control bit 4 runs or stops
// - counter0 bits 2:0 select prescaler ratio
// - external edges bypass the prescaler
// - bit 3 picks active pin edge
// - counter0 prescaled clock, counter1 clock/4
// - event mode counts selected pin edges
// - count to all ones, then overflow request
// - overflow reloads preload, counting continues
// - preload has no reset value
// - stopped: preload write also loads counter
// - running: preload write waits for reload
// - counter1 low write goes to buffer
// - high write loads high plus buffer
// - high read latches low byte
// - counter0 and high-byte reads return present count
// - mode 10 is timer
// - mode 01 is event counting
// - edge bit low rising, high falling
// - pulse width ends, run clears itself
module dtc_top (
  input  wire logic                       clk,                   // 200 MHz system clock
  input  wire logic                       rst,                   // sync reset
  input  wire logic                       ce,                    // clock enable
  input  wire logic [dtc_pkg::SEL_W-1:0]  reg_sel,               // register select
  input  wire logic                       reg_wr,                // write strobe
  input  wire logic                       reg_rd,                // read strobe
  input  wire logic [dtc_pkg::DATA_W-1:0] reg_wdata,             // write data
  output logic      [dtc_pkg::DATA_W-1:0] reg_rdata,             // read data, registered
  input  wire logic                       counter0_count_or_pin, // counter0 timer pin
  input  wire logic                       counter1_ext_pin,      // counter1 timer pin
  output logic                            counter0_irq,          // counter0 overflow pulse
  output logic                            counter1_irq           // counter1 overflow pulse
);
  import dtc_pkg::*;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire wr_c0_count = ce & reg_wr & (reg_sel == REG_C0_COUNT);
  wire wr_c1_low   = ce & reg_wr & (reg_sel == REG_C1_LOW);
  wire wr_c1_high  = ce & reg_wr & (reg_sel == REG_C1_HIGH);
  wire rd_c1_high  = ce & reg_rd & ~reg_wr & (reg_sel == REG_C1_HIGH);

  wire [1:0] ctrl_wr;
  assign ctrl_wr[0] = ce & reg_wr & (reg_sel == REG_C0_CTRL);
  assign ctrl_wr[1] = ce & reg_wr & (reg_sel == REG_C1_CTRL);

  wire [DATA_W-1:0] ctrl_mask [2];
  assign ctrl_mask[0] = C0_CTRL_MASK;
  assign ctrl_mask[1] = C1_CTRL_MASK;

  // ---------------------------------------------------------------
  // time bases
  // ---------------------------------------------------------------
  logic [PSC_W-1:0]  prescale_q;
  logic [1:0]        insn_div_q;
  wire  [1:0][7:0]   ctrl_w;
  wire  [C0_W-1:0]   count0;
  wire  [C1_W-1:0]   count1;

  // free-running divider; a started timer may see a short first period
  always_ff @(posedge clk) begin
    if (rst) begin
      prescale_q <= '0;
      insn_div_q <= '0;
    end else if (ce) begin
      prescale_q <= prescale_q + 1'b1;
      insn_div_q <= insn_div_q + 1'b1;
    end
  end

  wire [2:0]       psc_sel   = ctrl_w[0][PSC_HI:PSC_LO];
  wire [7:0]       psc_pow   = 8'h01 << psc_sel;
  wire [7:0]       psc_full  = psc_pow - 8'h01;
  wire [PSC_W-1:0] psc_mask  = psc_full[PSC_W-1:0];

  wire [1:0] tick;
  assign tick[0] = (prescale_q & psc_mask) == psc_mask;
  assign tick[1] = insn_div_q == INSN_DIV_LAST;

  wire [1:0] pins = {counter1_ext_pin, counter0_count_or_pin};
  wire [1:0] inc;
  wire [1:0] pw_done;
  wire [1:0] ev_edge;

  // ---------------------------------------------------------------
  // per-counter control and mode logic
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic    [DATA_W-1:0] ctrl_q;
    dtc_pw_e              pw_q;
    dtc_pw_e              pw_d;
    logic                 rise;
    logic                 fall;

    dtc_pin_edge u_edge (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .pin  (pins[i]),
      .rise (rise),
      .fall (fall)
    );

    wire [1:0] mode     = ctrl_q[MODE_HI:MODE_LO];
    wire       run      = ctrl_q[RUN_BIT];
    wire       edge_hi  = ctrl_q[EDGE_BIT];
    wire       act_edge = edge_hi ? fall : rise;
    // a pulse opens on the edge opposite to the one that closes it
    wire       pw_start = edge_hi ? rise : fall;
    wire       is_timer = mode == MODE_TIMER;
    wire       is_event = mode == MODE_EVENT;
    wire       is_pulse = mode == MODE_PULSE;

    assign ev_edge[i] = act_edge;
    assign ctrl_w[i]  = ctrl_q;

    always_comb begin
      pw_d = pw_q;
      case (pw_q)
        DTC_PW_WAIT: begin
          if (run && is_pulse && pw_start) begin
            pw_d = DTC_PW_MEAS;
          end
        end
        DTC_PW_MEAS: begin
          if (!run || !is_pulse || act_edge) begin
            pw_d = DTC_PW_WAIT;
          end
        end
        default: pw_d = DTC_PW_WAIT;
      endcase
    end

    assign pw_done[i] = (pw_q == DTC_PW_MEAS) & run & is_pulse & act_edge;

    // off mode (00) never counts; event counts ignore the prescaler
    assign inc[i] = run & ((is_timer & tick[i])
                         | (is_event & act_edge)
                         | (is_pulse & (pw_q == DTC_PW_MEAS) & tick[i]));

    // a software write in the same cycle as the automatic stop wins
    always_ff @(posedge clk) begin
      if (rst) begin
        ctrl_q <= CTRL_RESET;
        pw_q   <= DTC_PW_WAIT;
      end else if (ce) begin
        pw_q <= pw_d;
        if (ctrl_wr[i]) begin
          ctrl_q <= reg_wdata & ctrl_mask[i];
        end else if (pw_done[i]) begin
          ctrl_q[RUN_BIT] <= 1'b0;
        end
      end
    end

    a_pw_stop: assert property (@(posedge clk) disable iff (rst)
      ce && pw_done[i] && !ctrl_wr[i] |=> !ctrl_q[RUN_BIT] && pw_q == DTC_PW_WAIT)
      else $error("pulse end did not clear run");

    a_pw_no_early: assert property (@(posedge clk) disable iff (rst)
      ce && pw_q == DTC_PW_WAIT && is_pulse && !pw_start |-> !inc[i] ##1 pw_q == DTC_PW_WAIT)
      else $error("pulse mode counted before start edge");
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] low_buf_q;
  logic [DATA_W-1:0] rdata_q;
  logic              irq0_w;
  logic              irq1_w;

  dtc_count_core #(.W(C0_W)) u_c0 (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .inc     (inc[0]),
    .pre_wr  (wr_c0_count),
    .pre_val (reg_wdata),
    .running (ctrl_w[0][RUN_BIT]),
    .count_q (count0),
    .ovf_q   (irq0_w)
  );

  dtc_count_core #(.W(C1_W)) u_c1 (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .inc     (inc[1]),
    .pre_wr  (wr_c1_high),
    .pre_val ({reg_wdata, low_buf_q}),
    .running (ctrl_w[1][RUN_BIT]),
    .count_q (count1),
    .ovf_q   (irq1_w)
  );

  assign counter0_irq = irq0_w;
  assign counter1_irq = irq1_w;

  // ---------------------------------------------------------------
  // low-byte buffer and read port
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (reg_sel)
      REG_C0_COUNT: rd_mux = count0;
      REG_C1_LOW:   rd_mux = low_buf_q;
      REG_C1_HIGH:  rd_mux = count1[C1_W-1:DATA_W];
      REG_C0_CTRL:  rd_mux = ctrl_w[0];
      REG_C1_CTRL:  rd_mux = ctrl_w[1];
      default:      rd_mux = RDATA_RESET;
    endcase
  end

  // one buffer serves both directions, so software must keep the
  // low-then-high write and high-then-low read order
  always_ff @(posedge clk) begin
    if (rst) begin
      low_buf_q <= '0;
      rdata_q   <= RDATA_RESET;
    end else if (ce) begin
      if (wr_c1_low) begin
        low_buf_q <= reg_wdata;
      end else if (rd_c1_high) begin
        low_buf_q <= count1[DATA_W-1:0];
      end
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_high_read;
    rd_c1_high;
  endsequence

  sequence s_low_read;
    ce && reg_rd && !reg_wr && reg_sel == REG_C1_LOW;
  endsequence

  a_low_latch: assert property (
    s_high_read |=> low_buf_q == $past(count1[DATA_W-1:0]))
    else $error("high read did not latch low byte");

  a_latched_read: assert property (
    s_high_read ##1 s_low_read |=> rdata_q == $past(low_buf_q))
    else $error("low read did not return latched byte");

  a_low_write: assert property (
    wr_c1_low && !inc[1] |=> count1 == $past(count1) && low_buf_q == $past(reg_wdata))
    else $error("low write disturbed counter");

  a_high_write: assert property (
    wr_c1_high && !ctrl_w[1][RUN_BIT] |=> count1 == {$past(reg_wdata), $past(low_buf_q)})
    else $error("high write did not merge buffer");

  a_event_hold: assert property (
    ce && ctrl_w[0][MODE_HI:MODE_LO] == MODE_EVENT && !ev_edge[0] && !wr_c0_count
    |=> count0 == $past(count0))
    else $error("event counter moved without pin edge");

  a_insn_div: assert property (
    ce && ctrl_w[1][RUN_BIT] && ctrl_w[1][MODE_HI:MODE_LO] == MODE_TIMER |-> inc[1] == tick[1])
    else $error("counter1 timer not on instruction clock");

  a_run_gate: assert property (
    ce && !ctrl_w[0][RUN_BIT] && !wr_c0_count |=> count0 == $past(count0))
    else $error("stopped counter0 moved");

endmodule // dtc_top

`default_nettype wire

/* File: dv/dtc_pin_src.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// external timer pin source
// ---------------------------------------------------------------
module dtc_pin_src (
  input  wire logic clk,   // system clock
  output var  logic pin0,  // counter0 timer pin
  output var  logic pin1   // counter1 timer pin
);
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
  end

  // a timer input always has a level, so the pins are never released
  task automatic drive(input int c, input logic v, input int hold);
    @(negedge clk);
    if (c == 0) begin
      pin0 = v;
    end else begin
      pin1 = v;
    end
    repeat (hold) @(negedge clk);
  endtask

  // nine cycles per level keeps each edge well past the synchroniser
  task automatic toggle(input int c, input int n);
    for (int i = 0; i < n; i++) begin
      drive(c, (c == 0) ? !pin0 : !pin1, 8);
    end
  endtask
endmodule // dtc_pin_src

`default_nettype wire

/* File: dv/tb_dtc_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_dtc_top;
  import dtc_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [SEL_W-1:0]  reg_sel = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq0;
  logic              irq1;
  wire  logic        pin0;
  wire  logic        pin1;
  int                mismatches = 0;
  int                total_checks = 0;
  logic [15:0]       v;
  int                n;

  always #2.5 clk = ~clk;

  dtc_top u_dut (
    .clk(clk), .rst(rst), .ce(ce), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .counter0_count_or_pin(pin0),
    .counter1_ext_pin(pin1), .counter0_irq(irq0), .counter1_irq(irq1)
  );

  dtc_pin_src u_src (.clk(clk), .pin0(pin0), .pin1(pin1));

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [SEL_W-1:0] s, input logic [7:0] d);
    @(negedge clk);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // read data lands on the edge after the strobe, so it is taken one negedge later
  task automatic rd(input logic [SEL_W-1:0] s, output logic [15:0] d);
    @(negedge clk);
    reg_sel = s;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = {8'h00, reg_rdata};
  endtask

  task automatic ctl(input int c, input logic [7:0] d);
    wr((c == 0) ? REG_C0_CTRL : REG_C1_CTRL, d);
  endtask

  task automatic setcnt(input int c, input logic [15:0] d);
    if (c == 0) begin
      wr(REG_C0_COUNT, d[7:0]);
    end else begin
      wr(REG_C1_LOW, d[7:0]);
      wr(REG_C1_HIGH, d[15:8]);
    end
  endtask

  task automatic getcnt(input int c, output logic [15:0] d);
    logic [15:0] hi;
    logic [15:0] lo;
    if (c == 0) begin
      rd(REG_C0_COUNT, d);
    end else begin
      // high then low on back-to-back cycles, strobe held across both
      @(negedge clk);
      reg_sel = REG_C1_HIGH;
      reg_rd = 1'b1;
      @(negedge clk);
      hi = {8'h00, reg_rdata};
      reg_sel = REG_C1_LOW;
      @(negedge clk);
      reg_rd = 1'b0;
      lo = {8'h00, reg_rdata};
      d = {hi[7:0], lo[7:0]};
    end
  endtask

  // counts negedges up to and including the one that sees the pulse
  task automatic wait_irq(input int c, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((((c == 0) ? irq0 : irq1) !== 1'b1) && (k < 3000));
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(REG_C0_CTRL, v);
    chk(v, 16'h0000);
    rd(REG_C1_CTRL, v);
    chk(v, 16'h0000);
    wr(3'h5, 8'hFF);
    rd(3'h5, v);
    chk(v, 16'h0000);
    ctl(0, 8'h2F);
    rd(REG_C0_CTRL, v);
    chk(v, 16'h000F);
    ctl(1, 8'h2F);
    rd(REG_C1_CTRL, v);
    chk(v, 16'h0008);
    // low write must sit in the buffer; the high read then overwrites it
    setcnt(1, 16'h0000);
    wr(REG_C1_LOW, 8'h77);
    getcnt(1, v);
    chk(v, 16'h0000);
    wr(REG_C1_HIGH, 8'hAB);
    getcnt(1, v);
    chk(v, 16'hAB00);
    setcnt(1, 16'h1234);
    getcnt(1, v);
    chk(v, 16'h1234);
    ctl(0, 8'h80);
    setcnt(0, 16'h0033);
    repeat (20) @(negedge clk);
    getcnt(0, v);
    chk(v, 16'h0033);
    ctl(0, 8'h10);
    repeat (20) @(negedge clk);
    getcnt(0, v);
    chk(v, 16'h0033);
    for (int k = 0; k < 8; k++) begin
      ctl(0, 8'h80 | 8'(k));
      setcnt(0, 16'h00FC);
      ctl(0, 8'h90 | 8'(k));
      wait_irq(0, n);
      wait_irq(0, n);
      chk(n[15:0], 16'(4 << k));
    end
    // clock enable low for 21 cycles must freeze the count one step after FC
    ctl(0, 8'h80);
    setcnt(0, 16'h00FC);
    ctl(0, 8'h90);
    wait_irq(0, n);
    @(negedge clk);
    ce = 1'b0;
    repeat (21) @(negedge clk);
    ce = 1'b1;
    wait_irq(0, n);
    chk(n[15:0], 16'd3);
    ctl(1, 8'h80);
    setcnt(1, 16'hFFF0);
    ctl(1, 8'h90);
    wait_irq(1, n);
    wait_irq(1, n);
    chk(n[15:0], 16'd64);
    setcnt(1, 16'hFF80);
    wait_irq(1, n);
    chk(16'(n + 4), 16'd64);
    wait_irq(1, n);
    chk(n[15:0], 16'd512);
    ctl(1, 8'h80);
    setcnt(1, 16'h12FC);
    ctl(1, 8'h90);
    rd(REG_C1_HIGH, v);
    chk(v, 16'h0012);
    repeat (40) @(negedge clk);
    rd(REG_C1_LOW, v);
    chk({15'h0000, v >= 16'h00FC}, 16'h0001);
    for (int c = 0; c < 2; c++) begin
      ctl(c, 8'h40);
      setcnt(c, 16'h0000);
      ctl(c, 8'h57);
      u_src.toggle(c, 7);
      getcnt(c, v);
      chk(v, 16'h0004);
      ctl(c, 8'h40);
      setcnt(c, 16'h0000);
      ctl(c, 8'h5F);
      u_src.toggle(c, 5);
      getcnt(c, v);
      chk(v, 16'h0003);
    end
    ctl(0, 8'h00);
    setcnt(0, 16'h0000);
    u_src.drive(0, 1'b1, 10);
    ctl(0, 8'hD0);
    u_src.drive(0, 1'b0, 40);
    u_src.drive(0, 1'b1, 10);
    getcnt(0, v);
    chk({15'h0000, v >= 16'd38 && v <= 16'd44}, 16'h0001);
    rd(REG_C0_CTRL, v);
    chk(v, 16'h00C0);
    ctl(1, 8'h00);
    setcnt(1, 16'h0000);
    ctl(1, 8'hD8);
    u_src.drive(1, 1'b1, 80);
    u_src.drive(1, 1'b0, 10);
    getcnt(1, v);
    chk({15'h0000, v >= 16'd19 && v <= 16'd22}, 16'h0001);
    rd(REG_C1_CTRL, v);
    chk(v, 16'h00C8);
    test_done();
  end

  // the whole sequence needs under 6000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule // tb_dtc_top

`default_nettype wire
